/* File: src/uart_fmt_pkg.sv */
package uart_fmt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // mode register location and reset image
  localparam logic [7:0] SMC_ADDR = 8'hA9;
  localparam logic [7:0] SMC_RESET = 8'h0C;
  localparam logic [7:0] READ_IDLE = 8'h00; // read data outside a read

  ////////////////////////////////////////////////////////////////////////////
  // field positions inside the mode register
  localparam int MPF_BIT = 7; // multiproc_filter_en
  localparam int PT_HI = 6; // parity_type_sel
  localparam int PT_LO = 5;
  localparam int PEN_BIT = 4; // parity_gen_en
  localparam int CL_HI = 3; // char_length_sel
  localparam int CL_LO = 2;
  localparam int XBE_BIT = 1; // extra_bit_en
  localparam int SBL_BIT = 0; // stop_len_sel

  ////////////////////////////////////////////////////////////////////////////
  // parity type codes
  localparam logic [1:0] PT_ODD = 2'h0;
  localparam logic [1:0] PT_EVEN = 2'h1;
  localparam logic [1:0] PT_MARK = 2'h2;
  localparam logic [1:0] PT_SPACE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // framing and timing
  localparam logic [2:0] LEN_BASE_IDX = 3'h4; // last bit index, 5-bit data
  localparam logic [1:0] LEN_MAX_CODE = 2'h3; // code of the 8-bit length
  localparam logic [3:0] OS_MID = 4'h7; // mid-bit tick of the start bit
  localparam logic [3:0] OS_LAST = 4'hF; // 16 baud ticks per bit time
  localparam int FIFO_DEPTH = 4;
  localparam int RX_WORD_W = 9; // parity fault bit over 8 data bits

  // frame position, shared by transmitter and receiver
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_EXTRA = 3'b011,
    ST_STOP1 = 3'b100,
    ST_STOP2 = 3'b101
  } frame_state_e;

endpackage

/* File: src/uart_fifo.sv */
module uart_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  logic [AW-1:0] wp_r, wp_nxt; // write index
  logic [AW-1:0] rp_r, rp_nxt; // read index
  logic [AW:0] cnt_r, cnt_nxt; // occupancy, one bit wider than index
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic wr, rd;

  ////////////////////////////////////////////////////////////////////////////
  // honest full and empty straight from the count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    wp_nxt = wr ? AW'(wp_r + 1'b1) : wp_r;
    rp_nxt = rd ? AW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = (AW+1)'(cnt_r + (AW+1)'(wr) - (AW+1)'(rd));
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // one storage entry per slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_comb begin
      mem_nxt[i] = (wr && wp_r == AW'(i)) ? in_data : mem_r[i];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        mem_r[i] <= '0;
      end else begin
        mem_r[i] <= mem_nxt[i];
      end
    end
  end

endmodule

/* File: src/uart_frame_format.sv */
module uart_frame_format
  import uart_fmt_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic baud_tick,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic tx_extra_value,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  output logic txd,
  input wire logic rxd,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_done_flag,
  input wire logic rx_done_clr,
  output logic parity_fault_flag,
  input wire logic parity_fault_clr,
  output logic rx_overrun
);

  // mode register and its fields
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic mpf_en, pen, xbe, sbl, ext_on;
  logic [1:0] ptype, clen;
  logic [7:0] len_mask; // keeps only the bits of the selected length
  logic [2:0] data_last; // index of the last data bit

  // transmitter
  frame_state_e tx_st_r, tx_st_nxt;
  logic [3:0] tx_os_r, tx_os_nxt; // baud ticks inside the bit
  logic [2:0] tx_idx_r, tx_idx_nxt;
  logic [7:0] tx_sh_r, tx_sh_nxt;
  logic tx_ext_r, tx_ext_nxt; // bit sent after the data field
  logic txd_r, txd_nxt;
  logic tx_end;

  // receiver and its line synchroniser
  logic rx_s1_r, rx_s2_r, rx_s3_r;
  logic line_r, line_nxt;
  frame_state_e rx_st_r, rx_st_nxt;
  logic [3:0] rx_os_r, rx_os_nxt;
  logic [2:0] rx_idx_r, rx_idx_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic rx_ext_r, rx_ext_nxt;
  logic rx_samp, rx_last_stop, rx_push;
  logic [7:0] rx_byte;
  logic [RX_WORD_W-1:0] rx_word, head_word;
  logic fifo_in_ready;

  // flags
  logic done_r, done_nxt;
  logic pfault_r, pfault_nxt;
  logic ovr_r, ovr_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // parity bit for a masked data field
  function automatic logic parity_of(input logic [7:0] d,
                                     input logic [1:0] t);
    logic p;
    p = 1'b0;
    unique case (t)
      PT_ODD: p = ~^d; // total count of ones ends odd
      PT_EVEN: p = ^d;
      PT_MARK: p = 1'b1;
      PT_SPACE: p = 1'b0;
    endcase
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // field decode, live from the register
  assign mpf_en = cfg_r[MPF_BIT];
  assign ptype = cfg_r[PT_HI:PT_LO];
  assign pen = cfg_r[PEN_BIT];
  assign clen = cfg_r[CL_HI:CL_LO];
  assign xbe = cfg_r[XBE_BIT];
  assign sbl = cfg_r[SBL_BIT];
  // parity takes the extra position, so either enable opens it
  assign ext_on = pen | xbe;
  assign len_mask = 8'hFF >> (LEN_MAX_CODE - clen);
  assign data_last = LEN_BASE_IDX + {1'b0, clen};

  // register write and registered read answer
  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = READ_IDLE;
    if (sfr_wr && sfr_addr == SMC_ADDR) begin
      cfg_nxt = sfr_wdata;
    end
    if (sfr_rd && sfr_addr == SMC_ADDR) begin
      rdata_nxt = cfg_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= SMC_RESET;
      rdata_r <= READ_IDLE;
    end else begin
      cfg_r <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: start, data lsb first, optional extra, stop bits
  assign tx_ready = (tx_st_r == ST_IDLE);
  assign tx_end = baud_tick && tx_os_r == OS_LAST;

  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_os_nxt = tx_os_r;
    tx_idx_nxt = tx_idx_r;
    tx_sh_nxt = tx_sh_r;
    tx_ext_nxt = tx_ext_r;
    txd_nxt = txd_r;
    if (baud_tick) begin
      tx_os_nxt = 4'(tx_os_r + 4'h1);
    end
    unique case (tx_st_r)
      ST_IDLE: begin
        txd_nxt = 1'b1;
        if (tx_valid) begin
          // bit time restarts at load, so the start bit is full length
          tx_st_nxt = ST_START;
          tx_os_nxt = 4'h0;
          txd_nxt = 1'b0;
          tx_sh_nxt = tx_data & len_mask;
          // parity wins the extra slot over the software value
          tx_ext_nxt = pen ? parity_of(tx_data & len_mask, ptype)
                           : tx_extra_value;
        end
      end
      ST_START: begin
        if (tx_end) begin
          tx_st_nxt = ST_DATA;
          tx_idx_nxt = 3'h0;
          txd_nxt = tx_sh_r[0];
        end
      end
      ST_DATA: begin
        if (tx_end) begin
          if (tx_idx_r == data_last) begin
            if (ext_on) begin
              tx_st_nxt = ST_EXTRA;
              txd_nxt = tx_ext_r;
            end else begin
              tx_st_nxt = ST_STOP1;
              txd_nxt = 1'b1;
            end
          end else begin
            tx_idx_nxt = 3'(tx_idx_r + 3'h1);
            tx_sh_nxt = tx_sh_r >> 1;
            txd_nxt = tx_sh_r[1];
          end
        end
      end
      ST_EXTRA: begin
        if (tx_end) begin
          tx_st_nxt = ST_STOP1;
          txd_nxt = 1'b1;
        end
      end
      ST_STOP1: begin
        txd_nxt = 1'b1;
        if (tx_end) begin
          tx_st_nxt = sbl ? ST_STOP2 : ST_IDLE;
        end
      end
      ST_STOP2: begin
        if (tx_end) begin
          tx_st_nxt = ST_IDLE;
        end
      end
      default: begin
        tx_st_nxt = ST_IDLE;
        txd_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_r <= ST_IDLE;
      tx_os_r <= 4'h0;
      tx_idx_r <= 3'h0;
      tx_sh_r <= 8'h00;
      tx_ext_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_os_r <= tx_os_nxt;
      tx_idx_r <= tx_idx_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_ext_r <= tx_ext_nxt;
      txd_r <= txd_nxt;
    end
  end

  assign txd = txd_r;

  ////////////////////////////////////////////////////////////////////////////
  // line synchroniser: a level counts once stages two and three agree
  always_comb begin
    line_nxt = (rx_s2_r == rx_s3_r) ? rx_s3_r : line_r;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      line_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      line_r <= line_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: start checked mid-bit, then one sample per bit time
  assign rx_samp = baud_tick && rx_os_r == OS_LAST;
  assign rx_byte = rx_sh_r >> (LEN_MAX_CODE - clen);

  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_os_nxt = rx_os_r;
    rx_idx_nxt = rx_idx_r;
    rx_sh_nxt = rx_sh_r;
    rx_ext_nxt = rx_ext_r;
    rx_last_stop = 1'b0;
    if (baud_tick) begin
      rx_os_nxt = 4'(rx_os_r + 4'h1);
    end
    unique case (rx_st_r)
      ST_IDLE: begin
        rx_os_nxt = 4'h0;
        // a frame that skips the extra bit never passes the filter
        rx_ext_nxt = 1'b0;
        if (!line_r) begin
          rx_st_nxt = ST_START;
        end
      end
      ST_START: begin
        if (baud_tick && rx_os_r == OS_MID) begin
          // a glitch shorter than half a bit is not a start
          rx_st_nxt = line_r ? ST_IDLE : ST_DATA;
          rx_os_nxt = 4'h0;
          rx_idx_nxt = 3'h0;
        end
      end
      ST_DATA: begin
        if (rx_samp) begin
          rx_sh_nxt = {line_r, rx_sh_r[7:1]};
          rx_idx_nxt = 3'(rx_idx_r + 3'h1);
          if (rx_idx_r == data_last) begin
            rx_st_nxt = ext_on ? ST_EXTRA : ST_STOP1;
          end
        end
      end
      ST_EXTRA: begin
        if (rx_samp) begin
          rx_ext_nxt = line_r;
          rx_st_nxt = ST_STOP1;
        end
      end
      ST_STOP1: begin
        if (rx_samp) begin
          // a low stop bit drops the character
          rx_st_nxt = (line_r && sbl) ? ST_STOP2 : ST_IDLE;
          rx_last_stop = line_r && !sbl;
        end
      end
      ST_STOP2: begin
        if (rx_samp) begin
          rx_st_nxt = ST_IDLE;
          rx_last_stop = line_r;
        end
      end
      default: begin
        rx_st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_r <= ST_IDLE;
      rx_os_r <= 4'h0;
      rx_idx_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_ext_r <= 1'b0;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_os_r <= rx_os_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_ext_r <= rx_ext_nxt;
    end
  end

  // stop bits good, and extra bit high when filtering
  assign rx_push = rx_last_stop && (!mpf_en || rx_ext_r);
  // fault bit travels with the byte so it is judged at the FIFO head
  assign rx_word = {pen && (rx_ext_r != parity_of(rx_byte, ptype)),
                    rx_byte};

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer; when full the new character is lost, not the old
  uart_fifo #(
    .WIDTH(RX_WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(rx_push),
    .in_ready(fifo_in_ready),
    .in_data(rx_word),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(head_word)
  );

  assign rx_data = head_word[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // sticky done and parity flags, overrun a one-cycle pulse; a set in the clearing cycle wins
  always_comb begin
    // the done flag cannot clear while bytes wait in the buffer
    done_nxt = rx_push | (done_r & ~(rx_done_clr & ~rx_valid));
    pfault_nxt = (pen & rx_valid & head_word[8])
               | (pfault_r & ~parity_fault_clr);
    ovr_nxt = rx_push & ~fifo_in_ready;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done_r <= 1'b0;
      pfault_r <= 1'b0;
      ovr_r <= 1'b0;
    end else begin
      done_r <= done_nxt;
      pfault_r <= pfault_nxt;
      ovr_r <= ovr_nxt;
    end
  end

  assign rx_done_flag = done_r;
  assign parity_fault_flag = pfault_r;
  assign rx_overrun = ovr_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  rx_filter_a: assert property (
    rx_last_stop && mpf_en && !rx_ext_r && !rx_done_flag |=> !rx_done_flag)
    else $error("filtered frame raised receive completion");
  rx_flag_set_a: assert property (
    rx_push |=> rx_done_flag)
    else $error("receive flag missed at stop sample");
  tx_odd_par_a: assert property (
    tx_valid && tx_ready && pen && ptype == PT_ODD
    |=> (^tx_sh_r ^ tx_ext_r) == 1'b1)
    else $error("odd parity bit wrong");
  tx_even_par_a: assert property (
    tx_valid && tx_ready && pen && ptype == PT_EVEN
    |=> (^tx_sh_r ^ tx_ext_r) == 1'b0)
    else $error("even parity bit wrong");
  tx_no_extra_a: assert property (
    tx_st_r == ST_DATA && !pen && !xbe |=> tx_st_r != ST_EXTRA)
    else $error("extra slot sent with both enables off");
  tx_len_a: assert property (
    tx_st_r == ST_DATA ##1 tx_st_r != ST_DATA
    |-> $past(tx_idx_r) == LEN_BASE_IDX + {1'b0, clen})
    else $error("data field length wrong");
  tx_extra_val_a: assert property (
    tx_valid && tx_ready && !pen && xbe
    |=> tx_ext_r == $past(tx_extra_value))
    else $error("extra bit value not carried");
  tx_extra_ign_a: assert property (
    tx_valid && tx_ready && pen && ptype == PT_SPACE && tx_extra_value
    |=> !tx_ext_r)
    else $error("extra value leaked past parity");
  tx_stop_one_a: assert property (
    tx_st_r == ST_STOP1 && tx_end && !sbl |=> tx_st_r == ST_IDLE && txd)
    else $error("short stop not one bit time");
  tx_stop_two_a: assert property (
    tx_st_r == ST_STOP1 && tx_end && sbl |=> tx_st_r == ST_STOP2 && txd)
    else $error("long stop not two bit times");
  par_fault_a: assert property (
    pen && rx_valid && head_word[8] |=> parity_fault_flag)
    else $error("parity fault not flagged");

endmodule

/* File: test/uart_remote_node.sv */
////////////////////////////////////////////////////////////////////////////
// far serial node: sends frames onto rxd, samples frames off txd
module uart_remote_node (
  input wire logic mclk,
  input wire logic baud_tick,
  input wire logic txd,
  output logic rxd
);
  timeunit 1ns;
  timeprecision 1ns;

  // line idles at mark level; send drives it high again after every frame
  initial begin
    rxd = 1'b1;
  end

  // count baud ticks at the design's own rate
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk iff baud_tick);
  endtask

  // one bit time per bit, lsb first; caller supplies start and stops
  task automatic send(input logic [12:0] f, input int n);
    // start right after a tick-free edge: one fixed phase for every frame,
    // so a low stop bit has risen before the receiver rechecks a start
    @(posedge mclk iff !baud_tick);
    for (int i = 0; i < n; i++) begin
      @(negedge mclk);
      rxd = f[i];
      ticks(16);
    end
    @(negedge mclk);
    rxd = 1'b1;
  endtask

  // wait for a start edge, then sample each bit near its middle
  task automatic capture(output logic [12:0] f, input int n);
    int w;
    f = '0;
    w = 0;
    while (txd !== 1'b0 && w < 4000) begin
      @(posedge mclk);
      w++;
    end
    ticks(8);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      if (i < n - 1) begin
        ticks(16);
      end
    end
  endtask
endmodule

/* File: test/uart_frame_format_tb_top.sv */
module uart_frame_format_tb_top import uart_fmt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic mclk, rst_n, baud_tick, sfr_wr, sfr_rd, tx_extra_value, tx_valid;
  logic tx_ready, txd, rxd, rx_valid, rx_ready, rx_done_flag, rx_done_clr;
  logic parity_fault_flag, parity_fault_clr, rx_overrun;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, tx_data, rx_data;
  int mismatches, n_tests, ovr_seen, cycles;

  uart_frame_format i_dut (.mclk, .rst_n, .baud_tick, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .tx_extra_value, .tx_valid, .tx_ready,
    .tx_data, .txd, .rxd, .rx_valid, .rx_ready, .rx_data, .rx_done_flag,
    .rx_done_clr, .parity_fault_flag, .parity_fault_clr, .rx_overrun);

  uart_remote_node i_remote (.mclk, .baud_tick, .txd, .rxd);

  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock; baud tick every other cycle, so a bit is 32 cycles
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(negedge mclk) baud_tick <= ~baud_tick & rst_n;

  // hang guard: the whole run needs roughly 8.5k cycles
  always @(posedge mclk) begin
    cycles++;
    if (rx_overrun === 1'b1) ovr_seen++;
    if (cycles > 40000) begin
      mismatches++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask

  // read data is registered, so it is taken one cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
  endtask

  task automatic pop(output logic [7:0] d);
    @(negedge mclk);
    d = rx_data;
    rx_ready = 1'b1;
    @(negedge mclk);
    rx_ready = 1'b0;
  endtask

  // expected line image: start, data lsb first, extra slot, stop bits
  function automatic logic [12:0] frame(input logic [7:0] m,
      input logic [7:0] d, input logic xv, output int n);
    int nd;
    logic p;
    nd = 5 + int'(m[CL_HI:CL_LO]);
    frame = '0;
    for (int i = 0; i < nd; i++) frame[i+1] = d[i];
    p = ^frame;
    case (m[PT_HI:PT_LO])
      PT_ODD: p = ~p;
      PT_EVEN: p = p;
      PT_MARK: p = 1'b1;
      default: p = 1'b0;
    endcase
    n = nd + 1;
    // parity takes the extra slot ahead of the extra value
    if (m[PEN_BIT]) begin
      frame[n] = p;
      n++;
    end else if (m[XBE_BIT]) begin
      frame[n] = xv;
      n++;
    end
    frame[n] = 1'b1;
    n++;
    if (m[SBL_BIT]) begin
      frame[n] = 1'b1;
      n++;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic tx_case(input logic [7:0] m, input logic [7:0] d,
      input logic xv);
    logic [12:0] exp, got;
    int n;
    exp = frame(m, d, xv, n);
    reg_wr(SMC_ADDR, m);
    @(negedge mclk);
    tx_data = d;
    tx_extra_value = xv;
    tx_valid = 1'b1;
    @(negedge mclk);
    tx_valid = 1'b0;
    i_remote.capture(got, n);
    chk(got, exp);
    // frame must be over half a bit after the last stop's middle
    i_remote.ticks(10);
    @(negedge mclk);
    chk({12'h0, tx_ready}, 13'h1);
  endtask

  task automatic rx_case(input logic [7:0] m, input logic [7:0] d,
      input logic xv, input logic [12:0] flip, input logic keep,
      input logic pf);
    logic [12:0] f;
    logic [7:0] got;
    int n;
    f = frame(m, d, xv, n) ^ flip;
    reg_wr(SMC_ADDR, m);
    i_remote.send(f, n);
    repeat (4) @(negedge mclk);
    chk({12'h0, rx_valid}, {12'h0, keep});
    chk({12'h0, rx_done_flag}, {12'h0, keep});
    chk({12'h0, parity_fault_flag}, {12'h0, pf});
    pop(got);
    if (keep) chk({5'h0, got}, {5'h0, d});
    rx_done_clr = 1'b1;
    parity_fault_clr = 1'b1;
    @(negedge mclk);
    rx_done_clr = 1'b0;
    parity_fault_clr = 1'b0;
    @(negedge mclk);
    chk({11'h0, rx_done_flag, parity_fault_flag}, 13'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] d;
    reg_rd(SMC_ADDR, d);
    chk({5'h0, d}, {5'h0, SMC_RESET});
    reg_wr(SMC_ADDR, 8'hA5);
    reg_wr(8'h98, 8'hFF);
    reg_rd(SMC_ADDR, d);
    chk({5'h0, d}, 13'h0A5);
    reg_rd(8'h98, d);
    chk({5'h0, d}, {5'h0, READ_IDLE});
    $display("test regs done");
  endtask

  task automatic t_tx();
    for (int c = 0; c < 4; c++) tx_case(8'(c << 2), 8'hB5, 1'b0);
    for (int p = 0; p < 4; p++) begin
      tx_case(8'h1C | 8'(p << 5), 8'h5B, 1'b0);
    end
    tx_case(8'h0E, 8'h81, 1'b1);
    tx_case(8'h0E, 8'h81, 1'b0);
    tx_case(8'h3E, 8'h03, 1'b1);
    tx_case(8'h7E, 8'h03, 1'b1);
    tx_case(8'h0D, 8'hC3, 1'b0);
    $display("test tx done");
  endtask

  task automatic t_rx();
    rx_case(8'h0C, 8'hA7, 1'b0, 13'h0, 1'b1, 1'b0);
    rx_case(8'h00, 8'h15, 1'b0, 13'h0, 1'b1, 1'b0);
    rx_case(8'h3C, 8'h03, 1'b0, 13'h0, 1'b1, 1'b0);
    rx_case(8'h3C, 8'h03, 1'b0, 13'h200, 1'b1, 1'b1);
    rx_case(8'h0C, 8'h3C, 1'b0, 13'h200, 1'b0, 1'b0);
    rx_case(8'h8E, 8'h42, 1'b0, 13'h0, 1'b0, 1'b0);
    rx_case(8'h8E, 8'h42, 1'b1, 13'h0, 1'b1, 1'b0);
    $display("test rx done");
  endtask

  // reader stalls while five frames arrive; fourth slot is the last
  task automatic t_fifo();
    logic [7:0] got;
    logic [12:0] f;
    int n;
    reg_wr(SMC_ADDR, SMC_RESET);
    ovr_seen = 0;
    // frame length is known only once the image is built
    for (int i = 1; i <= 5; i++) begin
      f = frame(8'h0C, 8'(i), 1'b0, n);
      i_remote.send(f, n);
    end
    repeat (4) @(negedge mclk);
    chk(13'(ovr_seen), 13'h1);
    rx_done_clr = 1'b1;
    @(negedge mclk);
    rx_done_clr = 1'b0;
    @(negedge mclk);
    chk({12'h0, rx_done_flag}, 13'h1);
    for (int i = 1; i <= 4; i++) begin
      pop(got);
      chk({5'h0, got}, 13'(i));
    end
    chk({12'h0, rx_valid}, 13'h0);
    $display("test fifo done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    tx_extra_value = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    rx_ready = 1'b0;
    rx_done_clr = 1'b0;
    parity_fault_clr = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_fifo();
    results();
  end
endmodule
